// ==== pdm_mic_output.sv ====
/*
 * Digital output side of one PDM microphone: strap-selected half-period
 * slot on the shared data line, mode selection from the incoming clock
 * rate, and wake-up / mode-switch settling.
 * Assumes the PDM clock and strap arrive from pins (synchronised here),
 * the audio sample comes from logic on the core clock, and the pad
 * combines DATA_O and DATA_OE_O into the three-state data pin.
 */
// Summary of operation
// - left unit's bit captured on falling edge
// - right unit's bit captured on rising edge
// - release line after own half period
// - drive only own slot, even alone
// - strap low is right, high is left
// - strap latched once, later changes ignored
// - clock below 200 kHz enters sleep
// - sleep keeps data line released
// - valid data 6 ms after clock returns
// - 768 kHz clock selects low-power listening
// - settled output 6 ms after start-up
// - pulse density encodes amplitude
// - small constant offset on stream
// - output limited at digital full scale
// - band change switches mode, settles 3.5 ms
// - right drives after fall, left after rise
`default_nettype none

module pdm_mic_output
    import pdm_mic_pkg::*;
#(
    parameter int WAKE_CYCLES   = WAKE_CYC,
    parameter int SWITCH_CYCLES = SWITCH_CYC,
    parameter int SMP_W         = SAMPLE_W
) (
    input  wire logic                    CORE_CLK_I,
    input  wire logic                    RSTN_I,
    input  wire logic                    PDM_CLK_I,
    input  wire logic                    SELECT_I,
    input  wire logic signed [SMP_W-1:0] AUDIO_I,
    output logic                         DATA_O,
    output logic                         DATA_OE_O,
    output mode_t                        MODE_O,
    output logic                         SETTLED_O,
    output logic                         CONTINUOUS_LISTEN_O,
    output logic                         LEFT_HALF_SLOT_O
);

    localparam logic [PERIOD_W-1:0] SLEEP_PER = PERIOD_W'(SLEEP_PERIOD_CYC);
    localparam logic [PERIOD_W-1:0] LP_PER    = PERIOD_W'(LP_MIN_PERIOD_CYC);
    localparam logic [PERIOD_W-1:0] HQ_PER    = PERIOD_W'(HQ_MIN_PERIOD_CYC);
    localparam logic [MATCH_W-1:0]  HYST_N    = MATCH_W'(HYST_PERIODS);
    localparam logic [TIMER_W-1:0]  WAKE_N    = TIMER_W'(WAKE_CYCLES);
    localparam logic [TIMER_W-1:0]  SWITCH_N  = TIMER_W'(SWITCH_CYCLES);
    localparam logic [1:0]          STRAP_N   = 2'(STRAP_SETTLE_CYC);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic pclk_s1_q;
    logic pclk_s2_q;
    logic pclk_s3_q;
    logic sel_s1_q;
    logic sel_s2_q;
    logic pclk_rise;
    logic pclk_fall;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            pclk_s1_q <= 1'b0;
            pclk_s2_q <= 1'b0;
            pclk_s3_q <= 1'b0;
            sel_s1_q  <= 1'b0;
            sel_s2_q  <= 1'b0;
        end else begin
            pclk_s1_q <= PDM_CLK_I;
            pclk_s2_q <= pclk_s1_q;
            pclk_s3_q <= pclk_s2_q;
            sel_s1_q  <= SELECT_I;
            sel_s2_q  <= sel_s1_q;
        end
    end

    assign pclk_rise = pclk_s2_q & ~pclk_s3_q;
    assign pclk_fall = ~pclk_s2_q & pclk_s3_q;

    ////////////////////////////////////////////////////////////////////////////////
    // channel strap: caught once after reset release, then frozen
    logic [1:0] strap_cnt_q;
    logic [1:0] strap_cnt_d;
    logic       strap_done_q;
    logic       strap_done_d;
    logic       left_half_slot_q;
    logic       left_half_slot_d;

    always_comb begin
        strap_cnt_d      = strap_cnt_q;
        strap_done_d     = strap_done_q;
        left_half_slot_d = left_half_slot_q;
        if (!strap_done_q) begin
            if (strap_cnt_q == STRAP_N) begin
                left_half_slot_d = sel_s2_q;
                strap_done_d     = 1'b1;
            end else begin
                strap_cnt_d = strap_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            strap_cnt_q      <= 2'h0;
            strap_done_q     <= 1'b0;
            left_half_slot_q <= 1'b0;
        end else begin
            strap_cnt_q      <= strap_cnt_d;
            strap_done_q     <= strap_done_d;
            left_half_slot_q <= left_half_slot_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock-rate monitor, mode and settling timers
    logic [PERIOD_W-1:0] per_q;
    logic [PERIOD_W-1:0] per_d;
    logic [PERIOD_W-1:0] measured;
    mode_t               band;
    mode_t               cand_q;
    mode_t               cand_d;
    logic [MATCH_W-1:0]  match_q;
    logic [MATCH_W-1:0]  match_d;
    mode_t               mode_q;
    mode_t               mode_d;
    logic [TIMER_W-1:0]  timer_q;
    logic [TIMER_W-1:0]  timer_d;
    logic                waking_q;
    logic                waking_d;
    logic                driving_q;
    logic                driving_d;
    logic                settled_q;
    logic                settled_d;
    logic                listen_q;
    logic                listen_d;

    always_comb begin
        measured = per_q + PERIOD_W'(1);
        // a longer period than the sleep limit means a clock below 200 kHz
        if (measured > SLEEP_PER) begin
            band = MODE_SLEEP;
        end else if (measured > LP_PER) begin
            band = MODE_LOW_POWER_LISTEN;
        end else if (measured > HQ_PER) begin
            band = MODE_HIGH_QUALITY;
        end else begin
            band = MODE_ULTRASONIC;
        end

        per_d     = (per_q == SLEEP_PER) ? per_q : measured;
        cand_d    = cand_q;
        match_d   = match_q;
        mode_d    = mode_q;
        timer_d   = timer_q;
        waking_d  = waking_q;
        driving_d = driving_q;
        settled_d = settled_q;

        if (timer_q != '0) begin
            timer_d = timer_q - TIMER_W'(1);
            if (timer_q == TIMER_W'(1)) begin
                settled_d = 1'b1;
                if (waking_q) begin
                    driving_d = 1'b1;
                    waking_d  = 1'b0;
                end
            end
        end

        if (pclk_rise) begin
            per_d = '0;
            // band must repeat for several periods before the mode follows
            if (band == cand_q) begin
                match_d = (match_q == HYST_N) ? match_q : match_q + MATCH_W'(1);
            end else begin
                cand_d  = band;
                match_d = MATCH_W'(1);
            end
            if (match_d == HYST_N && band != mode_q && band != MODE_SLEEP) begin
                mode_d    = band;
                settled_d = 1'b0;
                // mid-wake band change restarts the full wake-up wait
                if (mode_q == MODE_SLEEP || waking_q) begin
                    timer_d   = WAKE_N;
                    waking_d  = 1'b1;
                    driving_d = 1'b0;
                end else begin
                    timer_d = SWITCH_N;
                end
            end
        end else if (per_q == SLEEP_PER) begin
            // a stopped clock also counts as below the sleep limit
            mode_d    = MODE_SLEEP;
            cand_d    = MODE_SLEEP;
            match_d   = '0;
            timer_d   = '0;
            waking_d  = 1'b0;
            driving_d = 1'b0;
            settled_d = 1'b0;
        end
        listen_d = (mode_d == MODE_LOW_POWER_LISTEN);
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            per_q     <= '0;
            cand_q    <= MODE_SLEEP;
            match_q   <= '0;
            mode_q    <= MODE_SLEEP;
            timer_q   <= '0;
            waking_q  <= 1'b0;
            driving_q <= 1'b0;
            settled_q <= 1'b0;
            listen_q  <= 1'b0;
        end else begin
            per_q     <= per_d;
            cand_q    <= cand_d;
            match_q   <= match_d;
            mode_q    <= mode_d;
            timer_q   <= timer_d;
            waking_q  <= waking_d;
            driving_q <= driving_d;
            settled_q <= settled_d;
            listen_q  <= listen_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data slot: drive after the edge opening our half, release after the other.
    // the synchroniser adds two to three core cycles, so release lags the
    // edge by up to 60 ns; fine for a sampling host, not pad-exact timing.
    logic own_start;
    logic own_end;
    logic enable;
    logic step;
    logic mod_bit;
    logic oe_q;
    logic oe_d;
    logic data_q;
    logic data_d;

    assign own_start = left_half_slot_q ? pclk_rise : pclk_fall;
    assign own_end   = left_half_slot_q ? pclk_fall : pclk_rise;
    assign enable    = driving_q && strap_done_q && (mode_q != MODE_SLEEP);
    assign step      = enable && own_start;

    pdm_sigma_delta #(
        .W      (SMP_W),
        .OFS_PC (DC_OFFSET_PCT)
    ) u_mod (
        .clk_i    (CORE_CLK_I),
        .rstn_i   (RSTN_I),
        .step_i   (step),
        .sample_i (AUDIO_I),
        .bit_o    (mod_bit)
    );

    always_comb begin
        oe_d   = oe_q;
        data_d = step ? mod_bit : data_q;
        if (!enable) begin
            oe_d = 1'b0;
        end else if (own_start) begin
            oe_d = 1'b1;
        end else if (own_end) begin
            oe_d = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            oe_q   <= 1'b0;
            data_q <= 1'b0;
        end else begin
            oe_q   <= oe_d;
            data_q <= data_d;
        end
    end

    assign DATA_O              = data_q;
    assign DATA_OE_O           = oe_q;
    assign MODE_O              = mode_q;
    assign SETTLED_O           = settled_q;
    assign CONTINUOUS_LISTEN_O = listen_q;
    assign LEFT_HALF_SLOT_O    = left_half_slot_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);

    property p_left_start;
        ($rose(oe_q) && left_half_slot_q) |-> $past(pclk_rise);
    endproperty
    a_left_start: assert property (p_left_start)
        else $error("left unit started driving without a rising edge");

    property p_right_start;
        ($rose(oe_q) && !left_half_slot_q) |-> $past(pclk_fall);
    endproperty
    a_right_start: assert property (p_right_start)
        else $error("right unit started driving without a falling edge");

    property p_release;
        (strap_done_q && own_end) |=> !oe_q;
    endproperty
    a_release: assert property (p_release)
        else $error("line not released after the other edge");

    property p_strap_hold;
        strap_done_q |=> strap_done_q && $stable(left_half_slot_q);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("latched channel strap changed");

    property p_sleep_entry;
        (per_q == SLEEP_PER && !pclk_rise) |=> (mode_q == MODE_SLEEP) ##1 !oe_q;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("slow clock did not force sleep and release");

    property p_sleep_quiet;
        (mode_q == MODE_SLEEP) |=> !oe_q;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("line driven while asleep");

    property p_wake_wait;
        $rose(driving_q) |-> $past(timer_q) == TIMER_W'(1) && $past(waking_q);
    endproperty
    a_wake_wait: assert property (p_wake_wait)
        else $error("output enabled before the wake-up time ran out");

    property p_switch;
        ($changed(mode_q) && mode_q != MODE_SLEEP) |->
            !settled_q && match_q == HYST_N && $past(pclk_rise);
    endproperty
    a_switch: assert property (p_switch)
        else $error("mode changed without hysteresis or settling restart");

    property p_listen;
        ##1 (listen_q == (mode_q == MODE_LOW_POWER_LISTEN));
    endproperty
    a_listen: assert property (p_listen)
        else $error("listen flag disagrees with mode");

    c_low_power: cover property (mode_q == MODE_LOW_POWER_LISTEN && settled_q);
    c_high_quality: cover property (mode_q == MODE_HIGH_QUALITY && settled_q);
    c_ultrasonic: cover property (mode_q == MODE_ULTRASONIC);
    c_drive: cover property ($rose(oe_q) ##[1:40] $fell(oe_q));

endmodule

`default_nettype wire

// ==== pdm_mic_pkg.sv ====
/*
 * Shared constants and types for the PDM microphone output block:
 * clock-band limits, settling times, sample width and the mode type.
 * Assumes a 50 MHz core clock; the band periods and the wake and switch cycle counts below are derived from it.
 */
`default_nettype none

package pdm_mic_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // core clock
    localparam int CORE_CLK_MHZ = 50;
    localparam int CORE_CLK_KHZ = CORE_CLK_MHZ * 1000;

    ////////////////////////////////////////////////////////////////////////////////
    // clock band limits, in kHz, and the matching period counts in core cycles
    localparam int SLEEP_FREQ_KHZ    = 200;
    localparam int LP_HQ_SPLIT_KHZ   = 1200;
    localparam int HQ_US_SPLIT_KHZ   = 4000;
    localparam int SLEEP_PERIOD_CYC  = CORE_CLK_KHZ / SLEEP_FREQ_KHZ;
    localparam int LP_MIN_PERIOD_CYC = CORE_CLK_KHZ / LP_HQ_SPLIT_KHZ;
    localparam int HQ_MIN_PERIOD_CYC = CORE_CLK_KHZ / HQ_US_SPLIT_KHZ;
    localparam int PERIOD_W          = 9;

    // consecutive periods in one band before the mode follows it
    localparam int HYST_PERIODS = 4;
    localparam int MATCH_W      = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // settling times
    localparam int WAKE_TIME_US   = 6000;
    localparam int SWITCH_TIME_US = 3500;
    localparam int WAKE_CYC       = WAKE_TIME_US * CORE_CLK_MHZ;
    localparam int SWITCH_CYC     = SWITCH_TIME_US * CORE_CLK_MHZ;
    localparam int TIMER_W        = 19;

    // strap sampling waits until the two-stage synchroniser is filled
    localparam int STRAP_SETTLE_CYC = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // modulator
    localparam int SAMPLE_W      = 16;
    localparam int DC_OFFSET_PCT = 3;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_LOW_POWER_LISTEN,
        MODE_HIGH_QUALITY,
        MODE_ULTRASONIC
    } mode_t;

endpackage

`default_nettype wire

// ==== pdm_sigma_delta.sv ====
/*
 * First-order sigma-delta modulator producing the 1-bit PDM stream.
 * Assumes step_i is a one-cycle pulse per output bit and sample_i is
 * a signed sample on the same clock.
 */
`default_nettype none

module pdm_sigma_delta
    import pdm_mic_pkg::*;
#(
    parameter int W      = SAMPLE_W,
    parameter int OFS_PC = DC_OFFSET_PCT
) (
    input  wire logic                clk_i,
    input  wire logic                rstn_i,
    input  wire logic                step_i,
    input  wire logic signed [W-1:0] sample_i,
    output logic                     bit_o
);

    localparam logic signed [W+1:0] FULL_SCALE = (W+2)'((1 << (W-1)) - 1);
    localparam logic signed [W+1:0] DC_OFFSET  = (W+2)'((((1 << (W-1)) - 1) * OFS_PC) / 100);

    logic signed [W+1:0] acc_q;
    logic signed [W+1:0] acc_d;
    logic signed [W+1:0] sum;
    logic signed [W+1:0] x_sat;
    logic signed [W+1:0] feedback;

    // bit is one while the integrator is non-negative
    assign bit_o = ~acc_q[W+1];

    always_comb begin
        sum = (W+2)'(sample_i) + DC_OFFSET;
        // input is clamped so the pulse density never passes full scale
        if (sum > FULL_SCALE) begin
            x_sat = FULL_SCALE;
        end else if (sum < -FULL_SCALE) begin
            x_sat = -FULL_SCALE;
        end else begin
            x_sat = sum;
        end
        // a zero input gives a near-alternating one/zero pattern, slightly ones-heavy from DC_OFFSET
        feedback = bit_o ? FULL_SCALE : -FULL_SCALE;
        acc_d    = step_i ? (acc_q + x_sat - feedback) : acc_q;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    property p_limit;
        @(posedge clk_i) disable iff (!rstn_i)
        step_i |-> (x_sat <= FULL_SCALE) && (x_sat >= -FULL_SCALE);
    endproperty
    a_limit: assert property (p_limit)
        else $error("modulator input exceeds full scale");

    property p_one_lowers;
        @(posedge clk_i) disable iff (!rstn_i)
        (step_i && bit_o) |=> (acc_q <= $past(acc_q));
    endproperty
    a_one_lowers: assert property (p_one_lowers)
        else $error("a one bit did not lower the integrator");

endmodule

`default_nettype wire

// ==== pdm_host_model.sv ====
/*
 * Host-side partner of the microphone: makes the PDM clock, resolves the
 * shared data wire and counts captured bits and slot use.
 * Assumes the bench's core clock and a wire with no pull-up or pull-down.
 */
`default_nettype none

module pdm_host_model (
    input  wire logic        clk_i,
    input  wire logic        run_i,
    input  wire logic        clr_i,
    input  wire logic        left_i,
    input  wire logic [7:0]  half_i,
    input  wire logic        data_i,
    input  wire logic        oe_i,
    output logic             pdm_clk_o,
    output logic [15:0]      own_o,
    output logic [15:0]      foreign_o,
    output logic [15:0]      ones_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0]  cnt;
    logic        wire_lvl;
    logic        last;
    logic [19:0] dec_q;

    // an undriven wire shows the inverse of its last level, never a held copy
    assign wire_lvl = oe_i ? data_i : ~last;

    // 20-bit decimator sum, but ones_o shows only its low 16 bits and wraps after 65536 ones
    assign ones_o = dec_q[15:0];

    initial begin
        pdm_clk_o = 1'b0;
        cnt       = 8'h00;
        last      = 1'b0;
        own_o     = 16'h0000;
        foreign_o = 16'h0000;
        dec_q     = 20'h00000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        last <= wire_lvl;
        if (!run_i) begin
            // clock stands still low outside use
            cnt       <= 8'h00;
            pdm_clk_o <= 1'b0;
        // a shorter half period set mid-run must not wait for the counter to wrap
        end else if (cnt >= half_i - 8'h01) begin
            cnt       <= 8'h00;
            pdm_clk_o <= ~pdm_clk_o;
        end else begin
            cnt <= cnt + 8'h01;
        end
        if (clr_i) begin
            own_o     <= 16'h0000;
            foreign_o <= 16'h0000;
            dec_q     <= 20'h00000;
        end else if (run_i && cnt >= half_i - 8'h01) begin
            // capture just before the edge; the own slot is the half ending here
            if (pdm_clk_o == left_i) begin
                own_o  <= own_o + 16'(oe_i);
                dec_q  <= dec_q + 20'(wire_lvl);
            end else begin
                foreign_o <= foreign_o + 16'(oe_i);
            end
        end
    end

endmodule

`default_nettype wire

// ==== tb_pdm_mic_output.sv ====
/*
 * Self-checking bench for the PDM microphone output block.
 * Assumes the host model as far side and short wake and switch counts.
 */
`default_nettype none

module tb_pdm_mic_output
    import pdm_mic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        string name;
        int    sel;
        int    lo;
        int    hi;
    } note_t;

    localparam int WAKE = 50;
    localparam int SW   = 30;

    logic                       clk;
    logic                       rstn;
    logic                       select;
    logic signed [SAMPLE_W-1:0] audio;
    logic                       run;
    logic                       clr;
    logic [7:0]                 half;
    logic                       pdm_clk;
    logic                       data;
    logic                       oe;
    mode_t                      mode;
    logic                       settled;
    logic                       listen;
    logic                       left;
    logic [15:0]                own;
    logic [15:0]                foreign;
    logic [15:0]                ones;
    note_t                      notes[$];
    int                         fails;
    int                         checked;

    pdm_mic_output #(.WAKE_CYCLES(WAKE), .SWITCH_CYCLES(SW), .SMP_W(SAMPLE_W)) dut (
        .CORE_CLK_I         (clk),
        .RSTN_I             (rstn),
        .PDM_CLK_I          (pdm_clk),
        .SELECT_I           (select),
        .AUDIO_I            (audio),
        .DATA_O             (data),
        .DATA_OE_O          (oe),
        .MODE_O             (mode),
        .SETTLED_O          (settled),
        .CONTINUOUS_LISTEN_O(listen),
        .LEFT_HALF_SLOT_O   (left)
    );

    pdm_host_model host (
        .clk_i    (clk),
        .run_i    (run),
        .clr_i    (clr),
        .left_i   (left),
        .half_i   (half),
        .data_i   (data),
        .oe_i     (oe),
        .pdm_clk_o(pdm_clk),
        .own_o    (own),
        .foreign_o(foreign),
        .ones_o   (ones)
    );

    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] obs(int s);
        case (s)
            0: obs = 16'(mode);
            1: obs = 16'(settled);
            2: obs = 16'(listen);
            3: obs = 16'(left);
            4: obs = 16'(oe);
            5: obs = own;
            6: obs = foreign;
            default: obs = ones;
        endcase
    endfunction

    task automatic note(string n, int s, int lo, int hi);
        notes.push_back('{n, s, lo, hi});
    endtask

    initial begin : watch
        note_t       n;
        logic [15:0] v;
        forever begin
            @(posedge clk);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                v = obs(n.sel);
                checked++;
                if ((^v === 1'bx) || v < n.lo || v > n.hi) begin
                    fails++;
                    $display("MISMATCH %s expected %0d..%0d seen %0d", n.name, n.lo, n.hi, v);
                end
            end
        end
    end

    task automatic test_done();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic do_reset(logic strap);
        rstn   = 1'b0;
        select = strap;
        run    = 1'b0;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (8) @(negedge clk);
        note("strap", 3, strap, strap);
        note("mode", 0, MODE_SLEEP, MODE_SLEEP);
        note("oe", 4, 0, 0);
    endtask

    task automatic pulse_clr();
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
    endtask

    // mode must follow within four periods plus sync, then settle in a bounded time
    task automatic go_band(int h, mode_t m, bit wake);
        int early;
        early = 0;
        half  = 8'(h);
        run   = 1'b1;
        for (int i = 0; i < 8 * h + 40 && mode !== m; i++) begin
            early += int'(oe === 1'b1);
            @(negedge clk);
        end
        pulse_clr();
        for (int i = 0; i < WAKE + 40 && settled !== 1'b1; i++) begin
            early += int'(oe === 1'b1);
            @(negedge clk);
        end
        note("mode", 0, m, m);
        note("settled", 1, 1, 1);
        note("listen", 2, m == MODE_LOW_POWER_LISTEN, m == MODE_LOW_POWER_LISTEN);
        if (wake)
            note("early_oe", 6, early, 0);
        else
            note("own_during_switch", 5, 1, 16'hFFFF);
    endtask

    task automatic check_slots(int n);
        pulse_clr();
        repeat (n * 2 * half) @(negedge clk);
        note("own_slot", 5, n - 1, n + 1);
        note("foreign_slot", 6, 0, 0);
    endtask

    task automatic density();
        int lo[3];
        int hi[3];
        lo = '{56, 0, 26};
        hi = '{65, 6, 40};
        for (int k = 0; k < 3; k++) begin
            if (k == 0)
                audio = 16'sh7FFF - 16'($urandom % 2000);
            else if (k == 1)
                audio = 16'sh8000;
            else
                audio = 16'($urandom % 200) - 16'sd100;
            pulse_clr();
            repeat (64 * 2 * half) @(negedge clk);
            note("ones", 7, lo[k], hi[k]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk     = 1'b0;
        rstn    = 1'b0;
        select  = 1'b0;
        audio   = 16'sh0000;
        run     = 1'b0;
        clr     = 1'b0;
        half    = 8'h20;
        fails   = 0;
        checked = 0;
        void'($urandom(32'h6E2DC989));
        for (int s = 0; s < 2; s++) begin
            do_reset(s[0]);
            select = ~s[0];
            go_band(32, MODE_LOW_POWER_LISTEN, 1'b1);
            check_slots(8);
            go_band(10, MODE_HIGH_QUALITY, 1'b0);
            density();
            go_band(6, MODE_ULTRASONIC, 1'b0);
            check_slots(8);
            run = 1'b0;
            repeat (300) @(negedge clk);
            note("mode", 0, MODE_SLEEP, MODE_SLEEP);
            repeat (20) begin
                note("oe", 4, 0, 0);
                @(negedge clk);
            end
            note("strap", 3, s, s);
            go_band(32, MODE_LOW_POWER_LISTEN, 1'b1);
            $display("test strap %0d done", s);
        end
        repeat (2) @(negedge clk);
        test_done();
    end

    // the whole sequence takes about 11k cycles
    initial begin
        #1000000;
        fails++;
        $display("MISMATCH watchdog expected done seen hang");
        test_done();
    end

endmodule

`default_nettype wire
